/* File: include/scs_pkg.sv */
// Package of constants and types for the supply class selection controller
package scs_pkg;
   // Class flag positions in the advertised class field
   localparam int CLS_W       = 5;
   localparam int CLS_5V      = 0;
   localparam int CLS_3V      = 1;
   localparam int CLS_1V8     = 2;
   localparam int CLS_D_RSV   = 3;
   localparam int CLS_E_RSV   = 4;
   localparam logic [CLS_W-1:0] CLS_NONE = 5'h00;
   // Corrupted answers allowed per class before stepping up
   localparam logic [1:0] RETRY_MAX = 2'h3;
   // Timing
   localparam int MCLK_MHZ       = 125;
   localparam int CARD_CLK_KHZ   = 3125;
   localparam int CLK_HALF_CYC   = (MCLK_MHZ * 1000) / (CARD_CLK_KHZ * 2);
   localparam logic [7:0] CLK_HALF = 8'(CLK_HALF_CYC);
   localparam int ACT_US         = 200;
   localparam int ACT_CYC        = ACT_US * MCLK_MHZ;
   localparam int ATR_WAIT_US    = 20000;
   localparam int ATR_WAIT_CYC   = ATR_WAIT_US * MCLK_MHZ;
   localparam int DEACT_US       = 100;
   localparam int DEACT_CYC      = DEACT_US * MCLK_MHZ;
   localparam int TMR_W          = 32;
   typedef logic [CLS_W-1:0] scs_cls_t;
   typedef enum logic [1:0] {
      SCS_RES_NONE,
      SCS_RES_GOOD,
      SCS_RES_BAD
   } scs_res_e;
endpackage

/* File: include/scs_clk_if.sv */
// Interface between the sequencer and its card clock divider
`timescale 1ns/1ps
interface scs_clk_if;
   logic run;
   logic clk_out;
   modport ctl (output run, input clk_out);
   modport gen (input run, output clk_out);
endinterface

/* File: rtl/scs_clk_div.sv */
// Card clock divider with an even duty cycle
`timescale 1ns/1ps
module scs_clk_div
   import scs_pkg::*;
(
   // Clock and reset
   input  wire logic  mclk,
   input  wire logic  rst_b,
   input  wire logic  ce,
   // Control
   scs_clk_if.gen     cif
);
   logic [7:0] cnt;
   logic       lvl;

   // Equal halves keep the high phase at half the period
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 8'h00;
         lvl <= 1'b0;
      end else if (ce) begin
         if (!cif.run) begin
            cnt <= 8'h00;
            lvl <= 1'b0;
         end else if (cnt == CLK_HALF - 8'h01) begin
            cnt <= 8'h00;
            lvl <= ~lvl;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   assign cif.clk_out = lvl;
endmodule

/* File: rtl/scs_sync.sv */
// Two flop synchroniser for pin inputs
`timescale 1ns/1ps
module scs_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* File: rtl/scs_top.sv */
// Terminal side supply class selection sequencer
`timescale 1ns/1ps
// What this block does
// - Finish class selection before other activity
// - First power at lowest terminal class
// - No answer: step to next higher class, if supported
// - Decode class flags of first good answer
// - Unsupported class: reactivate at advertised class
// - Corrupted answer: retry same class twice
// - After three corrupted, only next class
// - One flag bit per class
// - Terminal drives card clock, 1 to 5 MHz
// - Clock high phase 40 to 60 percent
module scs_top
   import scs_pkg::*;
#(
   parameter int ACT_CYCLES   = ACT_CYC,
   parameter int WAIT_CYCLES  = ATR_WAIT_CYC,
   parameter int DEACT_CYCLES = DEACT_CYC
) (
   // Clock and reset
   input  wire logic           mclk,
   input  wire logic           rst_b,
   input  wire logic           ce,
   // User orders
   input  wire logic           start,
   input  wire scs_pkg::scs_cls_t term_cls,
   // Answer decoder results (pins from the receive path)
   input  wire logic           atr_good,
   input  wire logic           atr_bad,
   input  wire scs_pkg::scs_cls_t atr_cls,
   // Card contacts
   output logic                vcc_en,
   output scs_pkg::scs_cls_t   vcc_sel,
   output logic                card_rst_b,
   output logic                card_clk,
   // Status
   output logic                busy,
   output logic                done,
   output logic                rejected,
   output scs_pkg::scs_cls_t   cls_used
);
   typedef enum logic [2:0] {
      SCS_IDLE,
      SCS_POWER,
      SCS_WAIT,
      SCS_DEACT,
      SCS_DONE,
      SCS_REJECT
   } scs_state_e;

   scs_state_e  state;
   scs_state_e  next_state;
   scs_cls_t    cls;
   scs_cls_t    next_cls;
   scs_cls_t    pend_cls;
   logic [1:0]  retries;
   logic [TMR_W-1:0] tmr;
   logic        good_s;
   logic        bad_s;
   scs_cls_t    cls_s;
   logic        first;
   logic        pwr_nx;
   logic        rst_nx;
   scs_res_e    res;
   scs_clk_if   cif ();

   // Answer indications come from outside this clock domain
   scs_sync #(.W(CLS_W + 2)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .d     ({atr_good, atr_bad, atr_cls}),
      .q     ({good_s, bad_s, cls_s})
   );

   // Card clock made here by division
   scs_clk_div u_div (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .cif   (cif)
   );

   // Lowest class the terminal supports is its highest flag bit
   function automatic scs_cls_t lowest(input scs_cls_t m);
      scs_cls_t r;
      r = CLS_NONE;
      for (int i = 0; i < CLS_W; i++) begin
         if (m[i]) r = scs_cls_t'(1) << i;
      end
      return r;
   endfunction

   // Next higher class is the next lower bit index
   function automatic scs_cls_t step_up(input scs_cls_t c, input scs_cls_t m);
      scs_cls_t r;
      r = c >> 1;
      return (r & m) != CLS_NONE ? r : CLS_NONE;
   endfunction

   // Class advertised by the card and also held by the terminal
   function automatic scs_cls_t pick(input scs_cls_t adv, input scs_cls_t m);
      return lowest(adv & m);
   endfunction

   // Classify the sampled answer
   always_comb begin
      if (bad_s) res = SCS_RES_BAD;
      else if (good_s) res = SCS_RES_GOOD;
      else res = SCS_RES_NONE;
   end

   // Next state and class decisions
   always_comb begin
      next_state = state;
      next_cls   = cls;
      case (state)
         SCS_IDLE: begin
            if (start) begin
               next_cls   = lowest(term_cls);
               next_state = (lowest(term_cls) == CLS_NONE) ? SCS_REJECT : SCS_POWER;
            end
         end
         SCS_POWER: begin
            if (tmr == '0) next_state = SCS_WAIT;
         end
         SCS_WAIT: begin
            // the first thing heard after reset is the answer
            if (res == SCS_RES_GOOD) begin
               if ((cls_s & cls) != CLS_NONE) next_state = SCS_DONE;
               else if (first && pick(cls_s, term_cls) != CLS_NONE) next_state = SCS_DEACT;
               else next_state = SCS_REJECT;
            end else if (res == SCS_RES_BAD) begin
               if (retries != RETRY_MAX - 2'h1) next_state = SCS_DEACT;
               else if (step_up(cls, term_cls) != CLS_NONE) next_state = SCS_DEACT;
               else next_state = SCS_REJECT;
            end else if (tmr == '0) begin
               if (step_up(cls, term_cls) != CLS_NONE) next_state = SCS_DEACT;
               else next_state = SCS_REJECT;
            end
         end
         SCS_DEACT: begin
            if (tmr == '0) begin
               next_cls   = pend_cls;
               next_state = SCS_POWER;
            end
         end
         SCS_DONE, SCS_REJECT: begin
            if (start) next_state = SCS_IDLE;
         end
         default: next_state = SCS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= SCS_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Class currently applied or about to be applied
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cls <= CLS_NONE;
      end else if (ce) begin
         cls <= next_cls;
      end
   end

   // Class chosen for the coming reactivation
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pend_cls <= CLS_NONE;
      end else if (ce && state == SCS_WAIT) begin
         if (res == SCS_RES_GOOD) pend_cls <= pick(cls_s, term_cls);
         else if (res == SCS_RES_BAD && retries != RETRY_MAX - 2'h1) pend_cls <= cls;
         else pend_cls <= step_up(cls, term_cls);
      end
   end

   // Consecutive corrupted answers at one class
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         retries <= 2'h0;
      end else if (ce) begin
         if (state == SCS_IDLE) retries <= 2'h0;
         else if (state == SCS_WAIT && res == SCS_RES_BAD) begin
            retries <= (retries == RETRY_MAX - 2'h1) ? 2'h0 : retries + 2'h1;
         end else if (state == SCS_WAIT && (res != SCS_RES_NONE || tmr == '0)) begin
            retries <= 2'h0;
         end
      end
   end

   // Only the first good answer may send the card to an advertised class
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         first <= 1'b0;
      end else if (ce) begin
         if (state == SCS_IDLE) first <= 1'b1;
         else if (state == SCS_WAIT && res == SCS_RES_GOOD) first <= 1'b0;
      end
   end

   // Phase timer loaded on each state change
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tmr <= '0;
      end else if (ce) begin
         if (next_state != state) begin
            case (next_state)
               SCS_POWER: tmr <= TMR_W'(ACT_CYCLES - 1);
               SCS_WAIT:  tmr <= TMR_W'(WAIT_CYCLES - 1);
               SCS_DEACT: tmr <= TMR_W'(DEACT_CYCLES - 1);
               default:   tmr <= '0;
            endcase
         end else if (tmr != '0) begin
            tmr <= tmr - TMR_W'(1);
         end
      end
   end

   // Supply and reset levels of the coming phase
   assign pwr_nx = (next_state == SCS_POWER || next_state == SCS_WAIT
                    || next_state == SCS_DONE);
   assign rst_nx = (next_state == SCS_WAIT || next_state == SCS_DONE);

   // Card supply switch
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         vcc_en <= 1'b0;
      end else if (ce) begin
         vcc_en <= pwr_nx;
      end
   end

   // Applied class, cleared while the supply is off
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         vcc_sel <= CLS_NONE;
      end else if (ce) begin
         vcc_sel <= pwr_nx ? next_cls : CLS_NONE;
      end
   end

   // Card reset released only once the supply has settled
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         card_rst_b <= 1'b0;
      end else if (ce) begin
         card_rst_b <= rst_nx;
      end
   end

   // Clock stops on the same edge as the supply; its first rise comes one mclk cycle short of half a card clock period after the supply
   assign cif.run  = pwr_nx;
   assign card_clk = cif.clk_out;

   // Selection in progress; nothing else may start until it ends
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
      end else if (ce) begin
         busy <= (next_state != SCS_IDLE && next_state != SCS_DONE
                  && next_state != SCS_REJECT);
      end
   end

   // Card powered and released at its class
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         done <= 1'b0;
      end else if (ce) begin
         done <= (next_state == SCS_DONE);
      end
   end

   // Card turned away with its contacts off
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rejected <= 1'b0;
      end else if (ce) begin
         rejected <= (next_state == SCS_REJECT);
      end
   end

   // Class in use, shown only once selection is done
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cls_used <= CLS_NONE;
      end else if (ce) begin
         cls_used <= (next_state == SCS_DONE) ? next_cls : CLS_NONE;
      end
   end
endmodule

/* File: dv/scs_top_sva.sv */
// Checker of the class sequencer contacts and outcomes
`timescale 1ns/1ps
module scs_top_sva
   import scs_pkg::*;
#(
   parameter int ACT_CYCLES = 8
) (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst_b,
   // Orders
   input wire scs_pkg::scs_cls_t term_cls,
   // Contacts
   input wire logic              vcc_en,
   input wire scs_pkg::scs_cls_t vcc_sel,
   input wire logic              card_rst_b,
   input wire logic              card_clk,
   // Status
   input wire logic              busy,
   input wire logic              done,
   input wire logic              rejected,
   input wire scs_pkg::scs_cls_t cls_used
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [7:0] gap;
   logic       seen;
   logic       clk_q;
   wire        tgl = card_clk != clk_q;
   // Cycles since the last card clock edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gap   <= 8'h00;
         seen  <= 1'b0;
         clk_q <= 1'b0;
      end else begin
         clk_q <= card_clk;
         gap   <= tgl ? 8'h00 : gap + 8'h01;
         seen  <= vcc_en && (seen || tgl);
      end
   end
   // Supply off for a whole deactivation, and a powered card
   sequence s_off;
      (!vcc_en)[*8];
   endsequence
   sequence s_live;
      vcc_en && card_rst_b;
   endsequence
   a_clk_off: assert property (!vcc_en |-> !card_clk)
      else $error("card clock runs with supply off");
   a_clk_duty: assert property (tgl && seen && vcc_en |-> gap >= 8'h0f && gap <= 8'h17)
      else $error("card clock phase out of range");
   a_sel_onehot: assert property (vcc_en |-> $onehot(vcc_sel))
      else $error("applied class not one hot");
   a_sel_term: assert property (vcc_en |-> (vcc_sel & term_cls) != 5'h00)
      else $error("class not offered by terminal");
   a_sel_held: assert property (vcc_en && $past(vcc_en) |-> $stable(vcc_sel))
      else $error("class changed while powered");
   a_rst_delay: assert property ($rose(card_rst_b) |->
      $past(vcc_en, ACT_CYCLES) && !$past(vcc_en, ACT_CYCLES + 1))
      else $error("card reset released at wrong time");
   a_deact_gap: assert property ($fell(vcc_en) |-> s_off)
      else $error("deactivation too short");
   a_done_live: assert property ($rose(done) |-> s_live ##0 (cls_used == vcc_sel))
      else $error("done without powered card");
   a_rej_off: assert property (rejected |-> !vcc_en && !card_rst_b && !card_clk)
      else $error("rejected card still powered");
   a_busy_end: assert property ($fell(busy) |-> done || rejected)
      else $error("selection ended without outcome");
endmodule
bind scs_top scs_top_sva #(.ACT_CYCLES(ACT_CYCLES)) u_scs_top_sva (.mclk, .rst_b,
   .term_cls, .vcc_en, .vcc_sel, .card_rst_b, .card_clk, .busy, .done, .rejected, .cls_used);

/* File: dv/scs_card_model.sv */
// Behavioural card answering after each reset release at a class it hears
`timescale 1ns/1ps
module scs_card_model
   import scs_pkg::*;
(
   // Clock and contacts
   input  wire logic              mclk,
   input  wire logic              card_rst_b,
   input  wire scs_pkg::scs_cls_t vcc_sel,
   // Card personality
   input  wire scs_pkg::scs_cls_t sup,
   input  wire scs_pkg::scs_cls_t heard,
   // Answer results
   output logic                   atr_good,
   output logic                   atr_bad,
   output scs_pkg::scs_cls_t      atr_cls
);
   int bad_left = 0;
   // Answer first after reset, only at a class it works at
   initial begin
      atr_good = 1'b0;
      atr_bad  = 1'b0;
      atr_cls  = 5'h1f;
      forever begin
         @(posedge card_rst_b);
         repeat (6) @(posedge mclk);
         if (card_rst_b && (vcc_sel & heard) != 5'h00) begin
            if (bad_left > 0) begin
               atr_bad <= 1'b1;
               bad_left--;
            end else begin
               atr_good <= 1'b1;
               atr_cls  <= sup;
            end
            repeat (2) @(posedge mclk);
            atr_good <= 1'b0;
            atr_bad  <= 1'b0;
            atr_cls  <= ~sup;
         end
      end
   end
endmodule

/* File: dv/test_supply_class_selection.sv */
// Self-checking bench of the supply class sequencer
`timescale 1ns/1ps
module test_supply_class_selection;
   import scs_pkg::*;
   logic     mclk = 1'b0;
   logic     rst_b = 1'b0;
   logic     start = 1'b0;
   logic     en_q = 1'b0;
   scs_cls_t term_cls = 5'h07;
   scs_cls_t sup = 5'h07;
   scs_cls_t heard = 5'h00;
   logic     atr_good, atr_bad, vcc_en, card_rst_b, card_clk, busy, done, rejected;
   scs_cls_t atr_cls, vcc_sel, cls_used;
   scs_cls_t log_q[$];
   int       mismatches = 0;
   int       n_compared = 0;
   int       cyc = 0;
   always #4 mclk = ~mclk;
   scs_top #(.ACT_CYCLES(8), .WAIT_CYCLES(64), .DEACT_CYCLES(8)) u_scs_top (.mclk, .rst_b,
      .ce(1'b1), .start, .term_cls, .atr_good, .atr_bad, .atr_cls, .vcc_en, .vcc_sel,
      .card_rst_b, .card_clk, .busy, .done, .rejected, .cls_used);
   scs_card_model u_scs_card_model (.mclk, .card_rst_b, .vcc_sel, .sup, .heard,
      .atr_good, .atr_bad, .atr_cls);
   // Log each applied class and bound the run
   always @(posedge mclk) begin
      if (vcc_en && !en_q)
         log_q.push_back(vcc_sel);
      en_q <= vcc_en;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic run(input scs_cls_t t, s, h, input int nb, input logic rej,
                      input scs_cls_t cls, input int n, input logic [19:0] seq);
      int i;
      @(posedge mclk);
      term_cls <= t;
      sup <= s;
      heard <= h;
      u_scs_card_model.bad_left = nb;
      log_q.delete();
      @(posedge mclk) start <= 1'b1;
      @(posedge mclk) start <= 1'b0;
      i = 0;
      while (done !== 1'b1 && rejected !== 1'b1 && i < 3000) begin
         @(posedge mclk);
         i++;
      end
      check(32'(i < 3000), 32'h1);
      check(rejected, rej);
      check(cls_used, cls);
      check(vcc_en, !rej);
      check(card_rst_b, !rej);
      check(busy, 1'b0);
      check(log_q.size(), n);
      for (i = 0; i < n && i < log_q.size(); i++)
         check(log_q[i], seq[i*5+:5]);
      @(posedge mclk) start <= 1'b1;
      @(posedge mclk) start <= 1'b0;
      repeat (10) @(posedge mclk); // Supply stays off a full deactivation
   endtask
   task automatic t_step();
      run(5'h07, 5'h02, 5'h02, 0, 1'b0, 5'h02, 2, {5'h02, 5'h04});
   endtask
   task automatic t_switch();
      run(5'h07, 5'h01, 5'h07, 0, 1'b0, 5'h01, 2, {5'h01, 5'h04});
   endtask
   task automatic t_corrupt();
      run(5'h07, 5'h07, 5'h07, 3, 1'b0, 5'h02, 4, {5'h02, 5'h04, 5'h04, 5'h04});
   endtask
   task automatic t_reject();
      run(5'h01, 5'h01, 5'h00, 0, 1'b1, 5'h00, 1, {5'h01});
   endtask
   task automatic t_no_next();
      run(5'h05, 5'h01, 5'h01, 0, 1'b1, 5'h00, 1, {5'h04});
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      t_step();
      t_switch();
      t_corrupt();
      t_reject();
      t_no_next();
      final_report();
   end
endmodule
